// File: hdl/usr_serial_port.v
// serial port: asynchronous receiver and synchronous slave transmit/receive
// assumes a same-clock register master and pins arriving from outside the clock domain
//
// Local design decisions: the register offsets and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
`include "usr_serial_regs.vh"

module usr_serial_port (
   // clock and reset
   input  wire       CORE_CLK,
   input  wire       NRST,
   // register port
   input  wire [2:0] ADDR,
   input  wire [7:0] WDATA,
   input  wire       WR_STB,
   input  wire       RD_STB,
   output reg  [7:0] RDATA,
   // serial pins
   input  wire       DT_IN,
   output reg        DT_OUT,
   output reg        DT_OE,
   input  wire       CK_IN,
   // power management
   input  wire       SLEEP,
   output reg        WAKE
);

   // state codes of the asynchronous receiver
   localparam [1:0] ST_IDLE  = 2'h0;
   localparam [1:0] ST_START = 2'h1;
   localparam [1:0] ST_DATA  = 2'h2;
   localparam [1:0] ST_STOP  = 2'h3;
   // software-visible control
   reg  [3:0]  rcv_ctrl_reg;         // port enable, rx9, single rx, continuous rx
   reg  [3:0]  xmt_ctrl_reg;         // clock source, tx9, tx enable, sync select
   reg         tx9_bit_reg;
   reg  [7:0]  baud_lo_reg;
   reg  [7:0]  baud_hi_reg;
   reg  [3:0]  irq_en_reg;
   // pin synchronisers
   reg         dt_s1_reg;
   reg         dt_s2_reg;
   reg         dt_prev_reg;
   reg         ck_s1_reg;
   reg         ck_s2_reg;
   reg         ck_prev_reg;
   // receiver
   reg  [1:0]  rx_state_reg;
   reg  [15:0] baud_cnt_reg;
   reg  [3:0]  tick_cnt_reg;
   reg  [3:0]  rx_bits_reg;
   reg  [8:0]  rx_shift_reg;         // receive_shift_reg
   reg         smp_a_reg;
   reg         smp_b_reg;
   reg         push_reg;
   reg  [9:0]  push_word_reg;        // framing error, nine data bits
   // receive buffer
   reg  [9:0]  fifo_mem [0:1];
   reg         fifo_wr_reg;
   reg         fifo_rd_reg;
   reg  [1:0]  fifo_cnt_reg;
   reg         overrun_reg;
   // transmitter
   reg  [7:0]  tx_data_reg;          // transmit_data_register
   reg         tx_full_reg;
   reg  [8:0]  tx_shift_reg;         // transmit_shift_reg
   reg  [3:0]  tx_bits_reg;
   reg         tx_busy_reg;
   // decoded modes
   wire        port_enable      = rcv_ctrl_reg[3];
   wire        rx_nine          = rcv_ctrl_reg[2];
   wire        single_rx_enable = rcv_ctrl_reg[1];
   wire        cont_rx_enable   = rcv_ctrl_reg[0];
   wire        clock_source     = xmt_ctrl_reg[3];
   wire        tx_nine          = xmt_ctrl_reg[2];
   wire        transmit_enable  = xmt_ctrl_reg[1];
   wire        sync_select      = xmt_ctrl_reg[0];
   wire        async_rx = cont_rx_enable & ~sync_select & port_enable;
   wire        slave    = sync_select & ~clock_source & port_enable;
   wire        slave_tx = slave & ~cont_rx_enable & ~single_rx_enable;
   wire        slave_rx = slave & ~slave_tx;       // single rx alone suffices
   wire [3:0]  rx_nbits = rx_nine ? `USR_BITS_NINE : `USR_BITS_EIGHT;
   wire [3:0]  tx_nbits = tx_nine ? `USR_BITS_NINE : `USR_BITS_EIGHT;
   // edges seen only after two synchroniser stages
   wire        dt_fall  = dt_prev_reg & ~dt_s2_reg;
   wire        ck_rise  = ~ck_prev_reg & ck_s2_reg;
   wire        ck_fall  = ck_prev_reg & ~ck_s2_reg;
   wire        tick     = (baud_cnt_reg == 16'h0000);
   wire        majority = (smp_a_reg & smp_b_reg) | (smp_a_reg & dt_s2_reg) |
                          (smp_b_reg & dt_s2_reg);
   wire [8:0]  sync_shift = {dt_s2_reg, rx_shift_reg[8:1]};
   // buffer bookkeeping
   wire        rd_data  = RD_STB & (ADDR == `USR_OFS_RCV_DATA);
   wire        pop      = rd_data & (fifo_cnt_reg != 2'h0);
   wire        fifo_full = (fifo_cnt_reg == 2'h2) & ~pop;
   wire [9:0]  fifo_top = fifo_mem[fifo_rd_reg];
   wire        rx_flag  = (fifo_cnt_reg != 2'h0);
   wire        tx_flag  = ~tx_full_reg;
   wire        tx_load  = slave_tx & transmit_enable & tx_full_reg & ~tx_busy_reg;
   wire        wr_tx    = WR_STB & (ADDR == `USR_OFS_XMT_DATA);

   // pin synchronisers; first stage feeds only the second
   always @(posedge CORE_CLK or negedge NRST) begin
      if (!NRST) begin
         dt_s1_reg   <= 1'b1;
         dt_s2_reg   <= 1'b1;
         dt_prev_reg <= 1'b1;
         ck_s1_reg   <= 1'b0;
         ck_s2_reg   <= 1'b0;
         ck_prev_reg <= 1'b0;
      end else begin
         dt_s1_reg   <= DT_IN;
         dt_s2_reg   <= dt_s1_reg;
         dt_prev_reg <= dt_s2_reg;
         ck_s1_reg   <= CK_IN;
         ck_s2_reg   <= ck_s1_reg;
         ck_prev_reg <= ck_s2_reg;
      end
   end

   // control register writes; control bits survive a port disable
   always @(posedge CORE_CLK or negedge NRST) begin
      if (!NRST) begin
         rcv_ctrl_reg <= `USR_RST_CTRL;
         xmt_ctrl_reg <= `USR_RST_CTRL;
         tx9_bit_reg  <= 1'b0;
         baud_lo_reg  <= `USR_RST_BAUD_LO;
         baud_hi_reg  <= `USR_RST_BAUD_HI;
         irq_en_reg   <= `USR_RST_IRQ_EN;
      end else if (WR_STB) begin
         case (ADDR)
            `USR_OFS_RCV_CTRL: rcv_ctrl_reg <= WDATA[`USR_RC_PORT_EN:`USR_RC_CONT_RX];
            `USR_OFS_XMT_CTRL: begin
               xmt_ctrl_reg <= WDATA[`USR_TC_CLK_SRC:`USR_TC_SYNC_SEL];
               tx9_bit_reg  <= WDATA[`USR_TC_TX9_BIT];
            end
            `USR_OFS_BAUD_LO: baud_lo_reg <= WDATA;
            `USR_OFS_BAUD_HI: baud_hi_reg <= WDATA;
            `USR_OFS_IRQ_EN:  irq_en_reg  <= WDATA[3:0];
            default: ;
         endcase
      end
   end

   // sixteen-times bit-rate tick; divisor is baud register plus one
   always @(posedge CORE_CLK or negedge NRST) begin
      if (!NRST) begin
         baud_cnt_reg <= 16'h0000;
      end else if (!async_rx || tick) begin
         baud_cnt_reg <= {baud_hi_reg, baud_lo_reg};
      end else begin
         baud_cnt_reg <= baud_cnt_reg - 16'h0001;
      end
   end

   // receiver: asynchronous frames and synchronous slave words share the shifter
   always @(posedge CORE_CLK or negedge NRST) begin
      if (!NRST) begin
         rx_state_reg  <= ST_IDLE;
         tick_cnt_reg  <= 4'h0;
         rx_bits_reg   <= 4'h0;
         rx_shift_reg  <= 9'h000;
         smp_a_reg     <= 1'b1;
         smp_b_reg     <= 1'b1;
         push_reg      <= 1'b0;
         push_word_reg <= 10'h000;
      end else begin
         push_reg <= 1'b0;
         if (overrun_reg || !(async_rx || slave_rx)) begin
            // held idle while overrun stands or receive is off
            rx_state_reg <= ST_IDLE;
            tick_cnt_reg <= 4'h0;
            rx_bits_reg  <= 4'h0;
         end else if (slave_rx) begin
            // master's falling clock edge samples the data line
            if (ck_fall) begin
               rx_shift_reg <= sync_shift;
               if (rx_bits_reg + 4'h1 == rx_nbits) begin
                  rx_bits_reg   <= 4'h0;
                  push_reg      <= 1'b1;
                  push_word_reg <= {1'b0, rx_nine ? sync_shift : {1'b0, sync_shift[8:1]}};
               end else begin
                  rx_bits_reg <= rx_bits_reg + 4'h1;
               end
            end
         end else begin
            case (rx_state_reg)
               ST_IDLE: begin
                  tick_cnt_reg <= 4'h0;
                  rx_bits_reg  <= 4'h0;
                  if (dt_fall) begin
                     rx_state_reg <= ST_START;
                  end
               end
               ST_START: begin
                  if (tick) begin
                     tick_cnt_reg <= tick_cnt_reg + 4'h1;
                     if (tick_cnt_reg == `USR_TICK_HALF) begin
                        tick_cnt_reg <= 4'h0;
                        // a high line here was a glitch: no error
                        rx_state_reg <= dt_s2_reg ? ST_IDLE : ST_DATA;
                     end
                  end
               end
               ST_DATA: begin
                  if (tick) begin
                     tick_cnt_reg <= tick_cnt_reg + 4'h1;
                     if (tick_cnt_reg == `USR_TICK_SMP_A) smp_a_reg <= dt_s2_reg;
                     if (tick_cnt_reg == `USR_TICK_SMP_B) smp_b_reg <= dt_s2_reg;
                     if (tick_cnt_reg == `USR_TICK_LAST) begin
                        rx_shift_reg <= {majority, rx_shift_reg[8:1]};
                        rx_bits_reg  <= rx_bits_reg + 4'h1;
                        if (rx_bits_reg + 4'h1 == rx_nbits) begin
                           rx_state_reg <= ST_STOP;
                        end
                     end
                  end
               end
               ST_STOP: begin
                  if (tick) begin
                     tick_cnt_reg <= tick_cnt_reg + 4'h1;
                     if (tick_cnt_reg == `USR_TICK_SMP_A) smp_a_reg <= dt_s2_reg;
                     if (tick_cnt_reg == `USR_TICK_SMP_B) smp_b_reg <= dt_s2_reg;
                     if (tick_cnt_reg == `USR_TICK_LAST) begin
                        // framing error belongs to this character only
                        push_reg      <= 1'b1;
                        push_word_reg <= {~majority,
                                          rx_nine ? rx_shift_reg : {1'b0, rx_shift_reg[8:1]}};
                        rx_state_reg  <= ST_IDLE;
                     end
                  end
               end
               default: rx_state_reg <= ST_IDLE;
            endcase
         end
      end
   end

   // two-entry receive buffer with overrun blocking
   always @(posedge CORE_CLK or negedge NRST) begin
      if (!NRST) begin
         fifo_wr_reg  <= 1'b0;
         fifo_rd_reg  <= 1'b0;
         fifo_cnt_reg <= 2'h0;
         overrun_reg  <= 1'b0;
      end else if (!port_enable) begin
         // disabling the port flushes everything
         fifo_wr_reg  <= 1'b0;
         fifo_rd_reg  <= 1'b0;
         fifo_cnt_reg <= 2'h0;
         overrun_reg  <= 1'b0;
      end else begin
         if (pop) fifo_rd_reg <= ~fifo_rd_reg;
         if (push_reg && !fifo_full) fifo_wr_reg <= ~fifo_wr_reg;
         fifo_cnt_reg <= fifo_cnt_reg + {1'b0, push_reg & ~fifo_full} - {1'b0, pop};
         // a character arriving with no room sets overrun and is dropped
         if (push_reg && fifo_full) begin
            overrun_reg <= 1'b1;
         end else if (!cont_rx_enable) begin
            overrun_reg <= 1'b0;
         end
      end
   end

   // buffer storage; no reset needed as the count guards every read
   always @(posedge CORE_CLK) begin
      if (push_reg && !fifo_full && port_enable) begin
         fifo_mem[fifo_wr_reg] <= push_word_reg;
      end
   end

   // transmit data register and slave shifter
   always @(posedge CORE_CLK or negedge NRST) begin
      if (!NRST) begin
         tx_data_reg  <= 8'h00;
         tx_full_reg  <= 1'b0;
         tx_shift_reg <= 9'h1ff;
         tx_bits_reg  <= 4'h0;
         tx_busy_reg  <= 1'b0;
         DT_OUT       <= 1'b1;
         DT_OE        <= 1'b0;
      end else if (!port_enable) begin
         tx_full_reg  <= 1'b0;
         tx_busy_reg  <= 1'b0;
         tx_bits_reg  <= 4'h0;
         DT_OUT       <= 1'b1;
         DT_OE        <= 1'b0;
      end else begin
         DT_OE <= slave_tx & transmit_enable;
         if (wr_tx) begin
            tx_data_reg <= WDATA;
         end
         // a write in the load cycle keeps the register full
         tx_full_reg <= (tx_full_reg & ~tx_load) | wr_tx;
         if (tx_load) begin
            // waiting word moves in only once the shifter is empty
            tx_shift_reg <= {tx9_bit_reg, tx_data_reg};
            tx_bits_reg  <= 4'h0;
            tx_busy_reg  <= 1'b1;
         end else if (tx_busy_reg) begin
            if (ck_rise) begin
               DT_OUT       <= tx_shift_reg[0];
               tx_shift_reg <= {1'b1, tx_shift_reg[8:1]};
            end
            if (ck_fall) begin
               tx_bits_reg <= tx_bits_reg + 4'h1;
               if (tx_bits_reg + 4'h1 == tx_nbits) begin
                  tx_busy_reg <= 1'b0;
               end
            end
         end
      end
   end

   // wake request, held while the cause stands during sleep
   always @(posedge CORE_CLK or negedge NRST) begin
      if (!NRST) begin
         WAKE <= 1'b0;
      end else begin
         WAKE <= SLEEP & port_enable &
                 ((irq_en_reg[`USR_EN_PERIPH_IE] & irq_en_reg[`USR_EN_TX_IE] & tx_flag) |
                  (irq_en_reg[`USR_EN_RX_IE] & rx_flag));
      end
   end

   // read data valid in the cycle after the strobe only
   always @(posedge CORE_CLK or negedge NRST) begin
      if (!NRST) begin
         RDATA <= 8'h00;
      end else if (!RD_STB) begin
         RDATA <= 8'h00;
      end else begin
         case (ADDR)
            `USR_OFS_RCV_CTRL: RDATA <= {rcv_ctrl_reg, 1'b0, fifo_top[9] & rx_flag, overrun_reg,
                                         fifo_top[8] & rx_flag};
            `USR_OFS_XMT_CTRL: RDATA <= {xmt_ctrl_reg, 2'h0, ~tx_busy_reg, tx9_bit_reg};
            `USR_OFS_RCV_DATA: RDATA <= rx_flag ? fifo_top[7:0] : 8'h00;
            `USR_OFS_BAUD_LO:  RDATA <= baud_lo_reg;
            `USR_OFS_BAUD_HI:  RDATA <= baud_hi_reg;
            `USR_OFS_FLAGS:    RDATA <= {6'h00, tx_flag, rx_flag};
            `USR_OFS_IRQ_EN:   RDATA <= {4'h0, irq_en_reg};
            default:           RDATA <= 8'h00;
         endcase
      end
   end

endmodule
`default_nettype wire

// File: pkg/usr_serial_regs.vh
// register map, field positions, reset values and timing counts of the serial port
// assumes a byte-wide register port with a three-bit word address
`ifndef USR_SERIAL_REGS_VH
`define USR_SERIAL_REGS_VH

// register offsets
`define USR_OFS_RCV_CTRL   3'h0
`define USR_OFS_XMT_CTRL   3'h1
`define USR_OFS_RCV_DATA   3'h2
`define USR_OFS_XMT_DATA   3'h3
`define USR_OFS_BAUD_LO    3'h4
`define USR_OFS_BAUD_HI    3'h5
`define USR_OFS_FLAGS      3'h6
`define USR_OFS_IRQ_EN     3'h7

// receive_control_status fields
`define USR_RC_PORT_EN     7
`define USR_RC_RX9_SEL     6
`define USR_RC_SINGLE_RX   5
`define USR_RC_CONT_RX     4
`define USR_RC_FRAME_ERR   2
`define USR_RC_OVERRUN     1
`define USR_RC_RX9_BIT     0

// transmit_control_status fields
`define USR_TC_CLK_SRC     7
`define USR_TC_TX9_SEL     6
`define USR_TC_TX_EN       5
`define USR_TC_SYNC_SEL    4
`define USR_TC_SHIFT_IDLE  1
`define USR_TC_TX9_BIT     0

// peripheral_flag_reg and peripheral_enable_reg fields
`define USR_FL_RX_FLAG     0
`define USR_FL_TX_FLAG     1
`define USR_EN_RX_IE       0
`define USR_EN_TX_IE       1
`define USR_EN_PERIPH_IE   2
`define USR_EN_GLOBAL_IE   3

// reset values
`define USR_RST_CTRL       4'h0
`define USR_RST_BAUD_LO    8'h00
`define USR_RST_BAUD_HI    8'h00
`define USR_RST_IRQ_EN     4'h0

// oversampling: sixteen ticks per bit
`define USR_TICK_LAST      4'hf
`define USR_TICK_HALF      4'h7
`define USR_TICK_SMP_A     4'hd
`define USR_TICK_SMP_B     4'he
`define USR_BITS_EIGHT     4'h8
`define USR_BITS_NINE      4'h9

`endif

// File: test/usr_serial_monitor.sv
// checker of the serial port: register readback, read data idling, pin enable, wake causes
// assumes it is bound onto the serial port top, all ports in the core clock domain
`timescale 1ns/1ps
`default_nettype none
module usr_serial_monitor (
   // clock and reset
   input wire logic       CORE_CLK,
   input wire logic       NRST,
   // register port
   input wire logic [2:0] ADDR,
   input wire logic [7:0] WDATA,
   input wire logic       WR_STB,
   input wire logic       RD_STB,
   input wire logic [7:0] RDATA,
   // pins and power
   input wire logic       DT_OE,
   input wire logic       SLEEP,
   input wire logic       WAKE
);
   logic [7:0] rc_reg, xc_reg, bl_reg, bh_reg;
   logic [3:0] ie_reg;
   logic       tx_ok;
   logic       wake_ok;
   // shadow of the writable control bits, read-only bits masked away
   always_ff @(posedge CORE_CLK or negedge NRST) begin
      if (!NRST) begin
         rc_reg <= 8'h00;
         xc_reg <= 8'h00;
         bl_reg <= 8'h00;
         bh_reg <= 8'h00;
         ie_reg <= 4'h0;
      end else if (WR_STB) begin
         case (ADDR)
            3'h0: rc_reg <= WDATA & 8'hf0;
            3'h1: xc_reg <= WDATA & 8'hf1;
            3'h4: bl_reg <= WDATA;
            3'h5: bh_reg <= WDATA;
            3'h7: ie_reg <= WDATA[3:0];
            default: ;
         endcase
      end
   end
   // slave transmit mode and wake enables as software set them
   assign tx_ok   = xc_reg[4] & ~xc_reg[7] & xc_reg[5] & rc_reg[7] & (rc_reg[5:4] == 2'b00);
   assign wake_ok = ie_reg[0] | (ie_reg[1] & ie_reg[2]);

   default clocking cb @(posedge CORE_CLK); endclocking
   default disable iff (!NRST);

   a_rdata_idle:
      assert property (!RD_STB |=> RDATA == 8'h00) else $error("read data not idle");
   a_baud_lo_read:
      assert property (RD_STB && ADDR == 3'h4 |=> RDATA == $past(bl_reg))
      else $error("baud low readback wrong");
   a_baud_hi_read:
      assert property (RD_STB && ADDR == 3'h5 |=> RDATA == $past(bh_reg))
      else $error("baud high readback wrong");
   a_irq_en_read:
      assert property (RD_STB && ADDR == 3'h7 |=> RDATA[3:0] == $past(ie_reg))
      else $error("enable readback wrong");
   a_rcv_ctrl_read:
      assert property (RD_STB && ADDR == 3'h0 |=> (RDATA & 8'hf0) == $past(rc_reg))
      else $error("receive control readback wrong");
   a_xmt_ctrl_read:
      assert property (RD_STB && ADDR == 3'h1 |=> (RDATA & 8'hf1) == $past(xc_reg))
      else $error("transmit control readback wrong");
   a_oe_mode:
      assert property (DT_OE |-> $past(tx_ok)) else $error("data pin driven outside slave tx");
   a_wake_sleep:
      assert property (WAKE |-> $past(SLEEP)) else $error("wake while not asleep");
   a_wake_cause:
      assert property (WAKE |-> $past(wake_ok)) else $error("wake without enabled cause");
endmodule

bind usr_serial_port usr_serial_monitor u_mon (
   .CORE_CLK(CORE_CLK),
   .NRST    (NRST),
   .ADDR    (ADDR),
   .WDATA   (WDATA),
   .WR_STB  (WR_STB),
   .RD_STB  (RD_STB),
   .RDATA   (RDATA),
   .DT_OE   (DT_OE),
   .SLEEP   (SLEEP),
   .WAKE    (WAKE)
);
`default_nettype wire

// File: test/usr_serial_partner.sv
// far-side model: remote asynchronous transmitter and synchronous clock master
// assumes a pulled-up data line whose resolved level comes back on DT_LINE
`timescale 1ns/1ps
`default_nettype none
module usr_serial_partner #(
   parameter int BIT_NS = 800
) (
   // driven lines
   output logic      DT_DRV,
   output logic      CK,
   // resolved data line
   input  wire logic DT_LINE
);
   // line idles high, clock stands low outside words
   initial begin
      DT_DRV = 1'b1;
      CK     = 1'b0;
   end
   // start, n data bits lsb first, chosen stop level, one idle bit
   task automatic send_async(input logic [8:0] d, input int n, input logic stop);
      DT_DRV = 1'b0;
      #(BIT_NS);
      for (int i = 0; i < n; i++) begin
         DT_DRV = d[i];
         #(BIT_NS);
      end
      DT_DRV = stop;
      #(BIT_NS);
      DT_DRV = 1'b1;
      #(BIT_NS);
   endtask
   // low pulse that is gone long before the start bit centre
   task automatic glitch();
      DT_DRV = 1'b0;
      #(BIT_NS / 4);
      DT_DRV = 1'b1;
      #(2 * BIT_NS);
   endtask
   // 200 ns clock per bit; sample mid low phase, clear of late output updates
   task automatic sync_xfer(input logic [8:0] tx, input int n, output logic [8:0] rx);
      rx = 9'h000;
      for (int i = 0; i < n; i++) begin
         CK     = 1'b1;
         DT_DRV = tx[i];
         #100;
         CK = 1'b0;
         #50;
         rx[i] = DT_LINE;
         #50;
      end
      DT_DRV = 1'b1;
   endtask
endmodule
`default_nettype wire

// File: test/usr_serial_port_tb.sv
// testbench of the serial port: async frames, overrun, synchronous slave words in sleep
// assumes the partner model on the pins and the checker bound onto the design
`timescale 1ns/1ps
`default_nettype none
module usr_serial_port_tb;
   logic       CORE_CLK = 1'b0;
   logic       NRST     = 1'b0;
   logic [2:0] ADDR     = 3'h0;
   logic [7:0] WDATA    = 8'h00;
   logic       WR_STB   = 1'b0;
   logic       RD_STB   = 1'b0;
   logic       SLEEP    = 1'b0;
   wire  [7:0] RDATA;
   wire        DT_OUT, DT_OE, CK_IN, WAKE, p_dt, dt_line;
   int         errors    = 0;
   int         cmp_count = 0;
   logic [8:0] v;
   // pin level: design drives when enabled, otherwise the far side
   assign dt_line = DT_OE ? DT_OUT : p_dt;
   always #12.5 CORE_CLK = ~CORE_CLK;
   usr_serial_port uut (.CORE_CLK(CORE_CLK), .NRST(NRST), .ADDR(ADDR), .WDATA(WDATA),
      .WR_STB(WR_STB), .RD_STB(RD_STB), .RDATA(RDATA), .DT_IN(dt_line), .DT_OUT(DT_OUT),
      .DT_OE(DT_OE), .CK_IN(CK_IN), .SLEEP(SLEEP), .WAKE(WAKE));
   usr_serial_partner #(.BIT_NS(800)) far (.DT_DRV(p_dt), .CK(CK_IN), .DT_LINE(dt_line));

   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge CORE_CLK);
      ADDR   <= a;
      WDATA  <= d;
      WR_STB <= 1'b1;
      @(posedge CORE_CLK);
      WR_STB <= 1'b0;
   endtask
   // read data taken one cycle after the strobe, once settled
   task automatic rd(input logic [2:0] a, output logic [7:0] d);
      @(posedge CORE_CLK);
      ADDR   <= a;
      RD_STB <= 1'b1;
      @(posedge CORE_CLK);
      RD_STB <= 1'b0;
      #1 d = RDATA;
   endtask
   task automatic chk(input logic [8:0] got, input logic [8:0] exp, input string msg);
      cmp_count++;
      if (got !== exp) begin
         errors++;
         $display("BAD %0t %s got %h exp %h", $time, msg, got, exp);
      end
   endtask
   task automatic rchk(input logic [2:0] a, input logic [7:0] m, input logic [7:0] e);
      logic [7:0] d;
      rd(a, d);
      chk({1'b0, d & m}, {1'b0, e}, "register value");
   endtask
   task automatic idle(input int n);
      repeat (n) @(posedge CORE_CLK);
      #1;
   endtask
   task automatic t_reset();
      chk({6'h00, DT_OUT, DT_OE, WAKE}, 9'h004, "pins after reset");
      rchk(3'h0, 8'hff, 8'h00);
      rchk(3'h1, 8'hf1, 8'h00);
      rchk(3'h4, 8'hff, 8'h00);
      rchk(3'h5, 8'hff, 8'h00);
      $display("test reset done");
   endtask
   // baud register 1: tick of 2 cycles, bit of 32 cycles = 800 ns
   task automatic t_async();
      wr(3'h4, 8'h01);
      wr(3'h0, 8'h90);
      far.send_async(9'h0a5, 8, 1'b1);
      rchk(3'h6, 8'h01, 8'h01);
      rchk(3'h0, 8'h04, 8'h00);
      rchk(3'h2, 8'hff, 8'ha5);
      rchk(3'h6, 8'h01, 8'h00);
      far.send_async(9'h00f, 8, 1'b0);
      rchk(3'h0, 8'h04, 8'h04);
      rchk(3'h2, 8'hff, 8'h0f);
      far.glitch();
      rchk(3'h6, 8'h01, 8'h00);
      far.send_async(9'h03c, 8, 1'b1);
      rchk(3'h2, 8'hff, 8'h3c);
      wr(3'h0, 8'h80);
      far.send_async(9'h055, 8, 1'b1);
      rchk(3'h6, 8'h01, 8'h00);
      $display("test async receive done");
   endtask
   // third completed character finds the buffer full
   task automatic t_overrun();
      wr(3'h0, 8'h90);
      far.send_async(9'h011, 8, 1'b1);
      far.send_async(9'h022, 8, 1'b1);
      far.send_async(9'h033, 8, 1'b1);
      rchk(3'h0, 8'h02, 8'h02);
      far.send_async(9'h044, 8, 1'b1);
      rchk(3'h2, 8'hff, 8'h11);
      rchk(3'h2, 8'hff, 8'h22);
      rchk(3'h6, 8'h01, 8'h00);
      wr(3'h0, 8'h80);
      rchk(3'h0, 8'h02, 8'h00);
      wr(3'h0, 8'hd0);
      far.send_async(9'h1a5, 9, 1'b1);
      rchk(3'h0, 8'h01, 8'h01);
      rchk(3'h2, 8'hff, 8'ha5);
      $display("test overrun and nine bits done");
   endtask
   // two words loaded, then sleep; second waits until the first is out
   task automatic t_slave_tx();
      wr(3'h0, 8'h00);
      wr(3'h7, 8'h06);
      wr(3'h1, 8'h71);
      wr(3'h0, 8'h80);
      wr(3'h3, 8'h3c);
      wr(3'h3, 8'hc3);
      @(posedge CORE_CLK);
      SLEEP <= 1'b1;
      idle(2);
      chk({7'h00, DT_OE, WAKE}, 9'h002, "slave tx pins");
      rchk(3'h6, 8'h02, 8'h00);
      far.sync_xfer(9'h1ff, 9, v);
      chk(v, 9'h13c, "first word");
      idle(4);
      chk({8'h00, WAKE}, 9'h001, "tx wake");
      rchk(3'h6, 8'h02, 8'h02);
      far.sync_xfer(9'h1ff, 9, v);
      chk(v, 9'h1c3, "second word");
      @(posedge CORE_CLK);
      SLEEP <= 1'b0;
      $display("test slave transmit done");
   endtask
   task automatic t_slave_rx();
      wr(3'h1, 8'h10);
      wr(3'h0, 8'h90);
      wr(3'h7, 8'h01);
      SLEEP <= 1'b1;
      far.sync_xfer(9'h05a, 8, v);
      idle(6);
      chk({7'h00, DT_OE, WAKE}, 9'h001, "rx wake");
      @(posedge CORE_CLK);
      SLEEP <= 1'b0;
      rchk(3'h2, 8'hff, 8'h5a);
      $display("test slave receive done");
   endtask
   task automatic final_report();
      $display("comparisons %0d mismatches %0d", cmp_count, errors);
      if (errors == 0 && cmp_count > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   // main sequence
   initial begin
      repeat (5) @(posedge CORE_CLK);
      NRST <= 1'b1;
      idle(1);
      t_reset();
      t_async();
      t_overrun();
      t_slave_tx();
      t_slave_rx();
      final_report();
   end
   // whole run is near 90 us; a hang is cut off well after that
   initial begin
      #1000000;
      errors++;
      $display("BAD %0t watchdog expired", $time);
      final_report();
   end
endmodule
`default_nettype wire
